// ==== design/nvm_protect_defs.vh ====
// Constants for the memory protection and identification block
`ifndef NVM_PROTECT_DEFS_VH
`define NVM_PROTECT_DEFS_VH

// Register word indexes; byte address is index times four
`define IDX_WRITE_PROTECT 22'h300006
`define IDX_CODE_PROTECT 22'h300008
`define IDX_READ_PROTECT 22'h30000a
`define IDX_SILICON_REV 22'h3ffffc
`define IDX_PART_ID 22'h3ffffe

// Write protection word fields
`define WP_LOWV 13
`define WP_SCAN 12
`define WP_EEPROM 10
`define WP_BOOT 9
`define WP_CONFIG 8
`define WP_BLOCK_LO 0
`define WP_MASK 16'h370f
`define WP_RESET 16'h370f

// Code protection word fields
`define CODE_DATA 1
`define CODE_PROGRAM 0
`define CODE_MASK 16'h0003
`define CODE_RESET 16'h0003

// Read protection word fields
`define RP_BOOT 9
`define RP_BLOCK_LO 0
`define RP_MASK 16'h020f
`define RP_RESET 16'h020f

// Region codes for write targets and table read source or target
`define REG_BOOT 3'h4
`define REG_CONFIG 3'h5
`define REG_EEPROM 3'h6
`define REG_OTHER 3'h7

// External read targets
`define EXT_PROGRAM 1'h0
`define EXT_DATA 1'h1

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ==== design/nvm_protection_config_and_id.v ====
// Memory protection configuration words, access gating and identity words
//
// Function
// - Refuse clearing low-voltage enable during low-voltage programming
// - Low-voltage enable forces pin to master clear
// - Scanner usable, gated by its disable bit
// - Scanner unavailable, disable bit ignored when clear
// - EEPROM writes blocked while its bit zero
// - Boot block writes blocked while its bit zero
// - Configuration writes blocked while its bit zero
// - Four user blocks each have write protect
// - Data memory code protected while its bit zero
// - Program memory code protected while its bit zero
// - Boot table reads from other blocks denied
// - User block table reads from others denied
// - Sixteen-bit read-only part identifier word
// - Top four revision bits hold family pattern
// - Six-bit read-only major revision field
// - Six-bit read-only minor revision field low
`timescale 1ns/1ps
`include "nvm_protect_defs.vh"

module nvm_protection_config_and_id #(
  // Arbitrary neutral identity values
  parameter [15:0] PART_ID = 16'h1234,
  parameter [3:0] FAMILY_PATTERN = 4'h5,
  parameter [5:0] MAJOR_REV = 6'h02,
  parameter [5:0] MINOR_REV = 6'h03
) (
  input wire sys_clk,
  input wire sys_rst,
  // AXI4-Lite slave
  input wire [23:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [23:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Pin: programming through the low-voltage interface
  input wire lowVoltageProgActive,
  // Master clear enable from the other configuration word
  input wire masterClearPinEnable,
  // Scanner disable bit from peripheral_disable_reg0
  input wire scannerModuleDisable,
  output reg masterClearIsReset,
  output reg scannerEnabled,
  output reg lowVoltageProgEnable,
  // Self-write or programmer write request to a region
  input wire nvmWrReq,
  input wire [2:0] nvmWrRegion,
  output reg nvmWrGrant,
  output reg nvmWrDeny,
  // Table read request
  input wire tblRdReq,
  input wire [2:0] tblRdSource,
  input wire [2:0] tblRdTarget,
  input wire [15:0] tblRdDataIn,
  output reg tblRdValid,
  output reg tblRdDenied,
  output reg [15:0] tblRdData,
  // External programmer read of program or data memory
  input wire extRdReq,
  input wire extRdTarget,
  input wire [15:0] extRdDataIn,
  output reg extRdValid,
  output reg extRdDenied,
  output reg [15:0] extRdData
);

  // Configuration words held by the block
  reg [15:0] writeProtectWord;
  reg [15:0] codeProtectWord;
  reg [15:0] readProtectWord;

  // Three-stage pin synchroniser and filtered level
  reg lowvSync1;
  reg lowvSync2;
  reg lowvSync3;
  reg lowvInterfaceActive;

  // Held write address and data
  reg awHeld;
  reg wHeld;
  reg [21:0] awIndex;
  reg [31:0] wData;
  reg [3:0] wStrb;

  // Next-value terms
  reg [15:0] next_writeProtectWord;
  reg [15:0] next_readProtectWord;
  reg [1:0] next_bresp;
  reg next_wrAllowed;
  reg next_tblAllowed;
  reg next_extAllowed;

  // Merge byte strobes into a 16-bit word
  function [15:0] strobeMerge;
    input [15:0] oldWord;
    input [31:0] newData;
    input [3:0] strb;
    begin
      strobeMerge = oldWord;
      if (strb[0]) begin
        strobeMerge[7:0] = newData[7:0];
      end
      if (strb[1]) begin
        strobeMerge[15:8] = newData[15:8];
      end
    end
  endfunction

  // Word read at an index; unmapped reads zero
  function [15:0] readWord;
    input [21:0] idx;
    input [15:0] wp;
    input [15:0] cw;
    input [15:0] rp;
    begin
      case (idx)
        `IDX_WRITE_PROTECT: readWord = wp & `WP_MASK;
        `IDX_CODE_PROTECT: readWord = cw & `CODE_MASK;
        `IDX_READ_PROTECT: readWord = rp & `RP_MASK;
        `IDX_SILICON_REV: readWord = {FAMILY_PATTERN, MAJOR_REV, MINOR_REV};
        `IDX_PART_ID: readWord = PART_ID;
        default: readWord = 16'h0000;
      endcase
    end
  endfunction

  // Whether an index exists in the map
  function isMapped;
    input [21:0] idx;
    begin
      case (idx)
        `IDX_WRITE_PROTECT: isMapped = 1'b1;
        `IDX_CODE_PROTECT: isMapped = 1'b1;
        `IDX_READ_PROTECT: isMapped = 1'b1;
        `IDX_SILICON_REV: isMapped = 1'b1;
        `IDX_PART_ID: isMapped = 1'b1;
        default: isMapped = 1'b0;
      endcase
    end
  endfunction

  // Pin synchroniser; first stage feeds only the second
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lowvSync1 <= 1'b0;
      lowvSync2 <= 1'b0;
      lowvSync3 <= 1'b0;
      lowvInterfaceActive <= 1'b0;
    end else begin
      lowvSync1 <= lowVoltageProgActive;
      lowvSync2 <= lowvSync1;
      lowvSync3 <= lowvSync2;
      // Change counts only when stages two and three agree
      if (lowvSync2 == lowvSync3) begin
        lowvInterfaceActive <= lowvSync3;
      end
    end
  end

  // Register write decode, applied once both halves are held
  always @* begin
    next_writeProtectWord = writeProtectWord;
    next_readProtectWord = readProtectWord;
    next_bresp = `RESP_OKAY;
    if (!isMapped(awIndex)) begin
      // Unmapped address
      next_bresp = `RESP_SLVERR;
    end else if (!writeProtectWord[`WP_CONFIG] &&
                 (awIndex == `IDX_WRITE_PROTECT ||
                  awIndex == `IDX_READ_PROTECT)) begin
      next_bresp = `RESP_SLVERR;
    end else if (awIndex == `IDX_WRITE_PROTECT) begin
      next_writeProtectWord =
        strobeMerge(writeProtectWord, wData, wStrb) & `WP_MASK;
      if (lowvInterfaceActive && writeProtectWord[`WP_LOWV]) begin
        next_writeProtectWord[`WP_LOWV] = 1'b1;
      end
    end else if (awIndex == `IDX_READ_PROTECT) begin
      next_readProtectWord =
        strobeMerge(readProtectWord, wData, wStrb) & `RP_MASK;
    end else begin
      // Read-only words ignore writes
      next_bresp = `RESP_SLVERR;
    end
  end

  // AXI write channels and configuration word storage
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awIndex <= 22'h000000;
      wData <= 32'h00000000;
      wStrb <= 4'h0;
      writeProtectWord <= `WP_RESET;
      readProtectWord <= `RP_RESET;
    end else begin
      // Address and data are taken in either order
      if (s_axi_awvalid && s_axi_awready) begin
        awIndex <= s_axi_awaddr[23:2];
        awHeld <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
        wHeld <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      // Commit once both halves are present
      if (awHeld && wHeld && !s_axi_bvalid) begin
        writeProtectWord <= next_writeProtectWord;
        readProtectWord <= next_readProtectWord;
        s_axi_bresp <= next_bresp;
        s_axi_bvalid <= 1'b1;
        awHeld <= 1'b0;
        wHeld <= 1'b0;
      end
      // Reopen both channels after the response is taken
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // AXI read channel
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {16'h0000, readWord(s_axi_araddr[23:2],
          writeProtectWord, codeProtectWord, readProtectWord)};
        s_axi_rresp <= isMapped(s_axi_araddr[23:2]) ?
          `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Code protection word is read-only from the bus
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      codeProtectWord <= `CODE_RESET;
    end else begin
      codeProtectWord <= codeProtectWord & `CODE_MASK;
    end
  end

  // Access permission decode for the three request ports
  always @* begin
    next_wrAllowed = 1'b0;
    case (nvmWrRegion)
      `REG_EEPROM: next_wrAllowed = writeProtectWord[`WP_EEPROM];
      `REG_BOOT: next_wrAllowed = writeProtectWord[`WP_BOOT];
      `REG_CONFIG: next_wrAllowed = writeProtectWord[`WP_CONFIG];
      `REG_OTHER: next_wrAllowed = 1'b0;
      default: next_wrAllowed =
        writeProtectWord[`WP_BLOCK_LO + nvmWrRegion[1:0]];
    endcase
    next_tblAllowed = 1'b1;
    if (tblRdSource != tblRdTarget) begin
      if (tblRdTarget == `REG_BOOT) begin
        next_tblAllowed = readProtectWord[`RP_BOOT];
      end else if (!tblRdTarget[2]) begin
        next_tblAllowed =
          readProtectWord[`RP_BLOCK_LO + tblRdTarget[1:0]];
      end
    end
    next_extAllowed = (extRdTarget == `EXT_DATA) ?
      codeProtectWord[`CODE_DATA] : codeProtectWord[`CODE_PROGRAM];
  end

  // Registered answers, one cycle after each request
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      nvmWrGrant <= 1'b0;
      nvmWrDeny <= 1'b0;
      tblRdValid <= 1'b0;
      tblRdDenied <= 1'b0;
      tblRdData <= 16'h0000;
      extRdValid <= 1'b0;
      extRdDenied <= 1'b0;
      extRdData <= 16'h0000;
    end else begin
      nvmWrGrant <= nvmWrReq && next_wrAllowed;
      nvmWrDeny <= nvmWrReq && !next_wrAllowed;
      tblRdValid <= tblRdReq;
      tblRdDenied <= tblRdReq && !next_tblAllowed;
      tblRdData <= (tblRdReq && next_tblAllowed) ?
        tblRdDataIn : 16'h0000;
      extRdValid <= extRdReq;
      extRdDenied <= extRdReq && !next_extAllowed;
      extRdData <= (extRdReq && next_extAllowed) ?
        extRdDataIn : 16'h0000;
    end
  end

  // Pin function and scanner availability
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      masterClearIsReset <= 1'b1;
      scannerEnabled <= 1'b0;
      lowVoltageProgEnable <= 1'b1;
    end else begin
      // otherwise high voltage entry is external
      masterClearIsReset <= writeProtectWord[`WP_LOWV] |
        masterClearPinEnable;
      lowVoltageProgEnable <= writeProtectWord[`WP_LOWV];
      scannerEnabled <= writeProtectWord[`WP_SCAN] &
        ~scannerModuleDisable;
    end
  end

endmodule // nvm_protection_config_and_id

// ==== bench/nvm_protect_sva.sv ====
// Port-level assertions for the protection and identity block
`timescale 1ns/1ps
`include "nvm_protect_defs.vh"
module nvm_protect_sva (
  input logic sys_clk,
  input logic sys_rst,
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic s_axi_bvalid,
  input logic scannerModuleDisable,
  input logic masterClearIsReset,
  input logic scannerEnabled,
  input logic lowVoltageProgEnable,
  input logic nvmWrReq,
  input logic [2:0] nvmWrRegion,
  input logic nvmWrGrant,
  input logic nvmWrDeny,
  input logic tblRdReq,
  input logic [2:0] tblRdSource,
  input logic [2:0] tblRdTarget,
  input logic [15:0] tblRdDataIn,
  input logic tblRdValid,
  input logic tblRdDenied,
  input logic [15:0] tblRdData,
  input logic extRdValid,
  input logic extRdDenied,
  input logic [15:0] extRdData
);
  // One clock domain, so clock and reset are given once
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  AST_LVP_MASTER_CLEAR_PIN: assert property (
    lowVoltageProgEnable |-> masterClearIsReset) else $error("master_clear_pin free");
  AST_SCAN_OFF: assert property (
    scannerEnabled |-> !$past(scannerModuleDisable)) else $error("scan on");
  AST_WR_ONE: assert property (
    nvmWrReq |=> nvmWrGrant != nvmWrDeny) else $error("write answer");
  AST_WR_IDLE: assert property (
    !nvmWrReq |=> !nvmWrGrant && !nvmWrDeny) else $error("stray answer");
  AST_WR_OTHER: assert property (
    nvmWrReq && nvmWrRegion == `REG_OTHER |=> nvmWrDeny)
    else $error("other granted");
  AST_TBL_SAME: assert property (
    tblRdReq && tblRdSource == tblRdTarget
    |=> tblRdValid && tblRdData == $past(tblRdDataIn))
    else $error("own block read");
  AST_TBL_DENY: assert property (
    tblRdDenied |-> tblRdValid && tblRdData == 16'h0000)
    else $error("denied data");
  AST_EXT_DENY: assert property (
    extRdDenied |-> extRdValid && extRdData == 16'h0000)
    else $error("denied external data");
  AST_AW_B: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("no write response");
endmodule // nvm_protect_sva
bind nvm_protection_config_and_id nvm_protect_sva nvm_protect_sva_inst (.*);

// ==== bench/nvm_array_model.sv ====
// Memory array and programmer model on the far side
`timescale 1ns/1ps
module nvm_array_model (
  input wire sys_clk,
  input wire lvStart,
  input wire lowVoltageProgEnable,
  input wire tblRdReq,
  input wire [2:0] tblRdTarget,
  input wire extRdReq,
  input wire extRdTarget,
  output wire lowVoltageProgActive,
  output wire [15:0] tblRdDataIn,
  output wire [15:0] extRdDataIn
);
  // Unread data lines change every cycle so stale data is never seen
  reg [15:0] idleWord = 16'h00ff;
  always @(posedge sys_clk) begin
    idleWord <= ~idleWord ^ 16'h0101;
  end
  assign lowVoltageProgActive = lvStart & lowVoltageProgEnable;
  assign tblRdDataIn = tblRdReq ? {8'hc3, 5'h00, tblRdTarget} : idleWord;
  assign extRdDataIn = extRdReq ? {8'h96, 7'h00, extRdTarget} : ~idleWord;
endmodule // nvm_array_model

// ==== bench/nvm_protection_config_and_id_bench.sv ====
// Self-checking bench for the protection and identity block
`timescale 1ns/1ps
`include "nvm_protect_defs.vh"
module nvm_protection_config_and_id_bench;
  localparam [23:0] WPA = {`IDX_WRITE_PROTECT, 2'h0};
  localparam [23:0] CPA = {`IDX_CODE_PROTECT, 2'h0};
  localparam [23:0] RPA = {`IDX_READ_PROTECT, 2'h0};
  localparam [23:0] IDA = {`IDX_PART_ID, 2'h0};
  // Identity values are arbitrary design defaults
  localparam [15:0] REV = {4'h5, 6'h02, 6'h03};
  reg sys_clk = 1'h0, sys_rst = 1'h1;
  reg s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
  // Ready to accept answers throughout
  reg s_axi_bready = 1'h1, s_axi_rready = 1'h1;
  reg [23:0] s_axi_awaddr = 24'h0, s_axi_araddr = 24'h0;
  reg [31:0] s_axi_wdata = 32'h0;
  reg [3:0] s_axi_wstrb = 4'h3;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  reg masterClearPinEnable = 1'h0, scannerModuleDisable = 1'h0;
  reg lvStart = 1'h0, nvmWrReq = 1'h0, tblRdReq = 1'h0, extRdReq = 1'h0;
  reg extRdTarget = 1'h0;
  reg [2:0] nvmWrRegion = 3'h0, tblRdSource = 3'h0, tblRdTarget = 3'h0;
  wire lowVoltageProgActive, masterClearIsReset, scannerEnabled;
  wire lowVoltageProgEnable, nvmWrGrant, nvmWrDeny, tblRdValid;
  wire tblRdDenied, extRdValid, extRdDenied;
  wire [15:0] tblRdDataIn, extRdDataIn, tblRdData, extRdData;
  wire [5:0] flags = {nvmWrGrant, nvmWrDeny, tblRdValid, tblRdDenied,
    extRdValid, extRdDenied};
  integer failCount = 0, checked = 0, cycles = 0;
  reg [31:0] seed = 32'h41;
  reg [15:0] wp = 16'h370f, rp = 16'h020f; // Shadow protection words
  reg [33:0] busQ[$];
  reg [21:0] sideQ[$];
  reg [33:0] busNote;
  reg [21:0] sideNote;

  nvm_protection_config_and_id nvm_protection_config_and_id_inst (.*);
  nvm_array_model nvm_array_model_inst (.*);

  initial forever #12.5 sys_clk = ~sys_clk;

  task check(input [31:0] exp, input [31:0] got, input string what);
    checked = checked + 1;
    if (exp !== got) begin
      failCount = failCount + 1;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  function [31:0] xs(input [31:0] s);
    reg [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    xs = x ^ (x << 5);
  endfunction

  // Expected side answer: {flags, data} from the shadow words
  function [21:0] sideExp(input [1:0] k, input [2:0] t, input [2:0] s);
    reg ok;
    case (k)
      2'h1: begin
        ok = s == t || t > 3'h4 || (t == 3'h4 ? rp[9] : rp[t]);
        sideExp = {2'h0, 1'h1, !ok, 2'h0, ok ? {8'hc3, 5'h00, t} : 16'h0};
      end
      2'h2: sideExp = {6'h02, 8'h96, 7'h00, t[0]};
      default: begin
        ok = t < 3'h4 ? wp[t] : t == 3'h4 ? wp[9] : t == 3'h5 ? wp[8] :
          t == 3'h6 && wp[10];
        sideExp = {ok, !ok, 20'h0};
      end
    endcase
  endfunction

  // Address and data offered together, each released when taken
  task wr(input [23:0] a, input [15:0] d, input [1:0] r);
    reg awDone, wDone;
    awDone = 1'h0;
    wDone = 1'h0;
    busQ.push_back({r, 32'h0});
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do begin
      @(posedge sys_clk);
      awDone = awDone | s_axi_awready;
      wDone = wDone | s_axi_wready;
      s_axi_awvalid <= !awDone;
      s_axi_wvalid <= !wDone;
    end while (!(awDone && wDone));
    do @(posedge sys_clk); while (!s_axi_bvalid);
  endtask

  task rd(input [23:0] a, input [15:0] d, input [1:0] r);
    busQ.push_back({r, 16'h0, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do @(posedge sys_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do @(posedge sys_clk); while (!s_axi_rvalid);
  endtask

  // Random back-to-back side requests, one kind per cycle
  task side_run(input integer n);
    integer i;
    for (i = 0; i < n; i = i + 1) begin
      @(posedge sys_clk);
      seed = xs(seed);
      nvmWrReq <= seed[1:0] == 2'h0 || seed[1:0] == 2'h3;
      tblRdReq <= seed[1:0] == 2'h1;
      extRdReq <= seed[1:0] == 2'h2;
      nvmWrRegion <= seed[4:2];
      tblRdTarget <= seed[4:2];
      tblRdSource <= seed[7:5];
      extRdTarget <= seed[2];
      masterClearPinEnable <= seed[8];
      scannerModuleDisable <= seed[9];
      sideQ.push_back(sideExp(seed[1:0] == 2'h3 ? 2'h0 : seed[1:0],
        seed[4:2], seed[7:5]));
    end
    @(posedge sys_clk);
    nvmWrReq <= 1'h0;
    tblRdReq <= 1'h0;
    extRdReq <= 1'h0;
  endtask

  task lvl;
    repeat (3) @(posedge sys_clk);
    check(wp[12] & !scannerModuleDisable, scannerEnabled, "scan");
    check(wp[13] | masterClearPinEnable, masterClearIsReset, "master_clear_pin");
    check(wp[13], lowVoltageProgEnable, "lowv");
  endtask

  // Take the oldest note whenever an answer shows
  always @(posedge sys_clk) begin
    if (s_axi_rvalid === 1'h1 || s_axi_bvalid === 1'h1) begin
      busNote = busQ.pop_front();
      check(busNote[33:32], s_axi_rvalid ? s_axi_rresp : s_axi_bresp, "resp");
      if (s_axi_rvalid) check(busNote[31:0], s_axi_rdata, "rdata");
    end
    if (flags !== 6'h00) begin
      sideNote = sideQ.pop_front();
      check(sideNote[21:16], flags, "flags");
      if (sideNote[19:18] != 0) check(sideNote[15:0], tblRdData, "tbl");
      if (sideNote[17:16] != 0) check(sideNote[15:0], extRdData, "ext");
    end
  end

  // Hang guard, far above the few hundred cycles needed
  always @(posedge sys_clk) begin
    cycles = cycles + 1;
    if (cycles == 8000) begin
      failCount = failCount + 1;
      print_verdict;
    end
  end

  task print_verdict;
    $display("checked %0d failCount %0d", checked, failCount);
    if (failCount == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'h0;
    @(posedge sys_clk);
    rd(WPA, 16'h370f, `RESP_OKAY);
    rd(CPA, 16'h0003, `RESP_OKAY);
    rd(RPA, 16'h020f, `RESP_OKAY);
    rd({`IDX_SILICON_REV, 2'h0}, REV, `RESP_OKAY);
    rd(IDA, 16'h1234, `RESP_OKAY);
    rd(24'h000010, 16'h0, `RESP_SLVERR);
    wr(CPA, 16'h0000, `RESP_SLVERR);
    wr(IDA, 16'h0000, `RESP_SLVERR);
    wr({`IDX_SILICON_REV, 2'h0}, 16'h0, `RESP_SLVERR);
    rd(CPA, 16'h0003, `RESP_OKAY);
    side_run(40);
    lvl;
    repeat (3) begin
      seed = xs(seed);
      wp = seed[15:0] & 16'h360f | 16'h2100;
      rp = seed[31:16] & 16'h020f;
      wr(WPA, wp, `RESP_OKAY);
      wr(RPA, rp, `RESP_OKAY);
      side_run(40);
      lvl;
    end
    // Clearing the enable during low-voltage programming keeps it set
    lvStart <= 1'h1;
    repeat (6) @(posedge sys_clk);
    wr(WPA, wp & 16'hdffe, `RESP_OKAY);
    wp = wp & 16'hfffe;
    rd(WPA, wp, `RESP_OKAY);
    lvStart <= 1'h0;
    repeat (6) @(posedge sys_clk);
    wp = wp & 16'hdfff;
    wr(WPA, wp, `RESP_OKAY);
    lvl;
    wp = wp & 16'hfeff;
    wr(WPA, wp, `RESP_OKAY);
    wr(RPA, 16'h0000, `RESP_SLVERR);
    wr(WPA, 16'h370f, `RESP_SLVERR);
    rd(WPA, wp, `RESP_OKAY);
    side_run(40);
    repeat (4) @(posedge sys_clk);
    check(0, sideQ.size() + busQ.size(), "notes");
    print_verdict;
  end
endmodule // nvm_protection_config_and_id_bench
